// [pkg/ssr_pkg.sv]
// shared constants and types for the serial sar readout block
package ssr_pkg;
  localparam int          RES_W        = 16;  // result width in bits
  localparam int          CNT_W        = 6;   // falling edge counter width
  localparam int          FIFO_W       = 20;  // width of one queued result
  localparam int          FIFO_DEPTH   = 8;   // results held for the user
  localparam int          TAG_W        = 4;   // cycle tag width
  // falling edges of the conversion clock, counted from select low
  localparam logic [5:0]  TRACK_FALLS  = 6'h05;  // sample_window end
  localparam logic [5:0]  CONV_FALLS   = 6'h10;  // approximation_window
  localparam logic [5:0]  MSB_LAST     = 6'h15;  // edge that resolves lsb
  localparam logic [5:0]  LSB_LAST     = 6'h24;  // last lsb-first bit
  localparam logic [5:0]  MIN_CYCLE    = 6'h16;  // full_cycle_length
  localparam logic [5:0]  CNT_RST      = 6'h00;
  localparam logic [15:0] TRIAL_FIRST  = 16'h8000;
  localparam logic [15:0] CODE_RST     = 16'h0000;
  localparam logic [3:0]  TAG_RST      = 4'h0;

  // one finished conversion as it travels through the queue
  typedef struct packed {
    logic [TAG_W-1:0] tag;   // rolling number of the queued result; aborted and skipped cycles take none
    logic [RES_W-1:0] code;  // straight binary result
  } ssr_result_t;

  // serial output pin
  typedef struct packed {
    logic data;
    logic oe;
  } ssr_pin_t;
endpackage

// [hdl/ssr_fifo.sv]
// shift-style result queue with valid and ready on both sides
`timescale 1ns/1ps
module ssr_fifo #(
  parameter int W     = 20,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         sys_rst,
  // fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] ONE  = CW'(1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic [CW-1:0] wr_idx;
  logic          push;
  logic          pop;
  logic          full;

  // head sits in mem[0] so the output is a plain flop
  assign push     = in_valid && !full;
  assign pop      = out_valid && out_ready;
  assign in_ready = !full;
  assign out_data = mem[0];
  assign wr_idx   = pop ? count - ONE : count;

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + ONE;
    end else if (pop && !push) begin
      next_count = count - ONE;
    end
  end

  // occupancy and flags, registered to keep the ports clean
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count     <= '0;
      full      <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      count     <= next_count;
      full      <= (next_count == FULL);
      out_valid <= (next_count != '0);
    end
  end

  // storage: shift on pop, write behind the last held word
  always_ff @(posedge clock) begin
    for (int j = 0; j < DEPTH; j++) begin
      if (push && wr_idx == CW'(j)) begin
        mem[j] <= in_data;
      end else if (pop) begin
        mem[j] <= (j == DEPTH - 1) ? mem[j] : mem[j+1];
      end
    end
  end
endmodule

// [hdl/ssr_readout.sv]
// conversion sequencing and serial readout of the sar converter
`timescale 1ns/1ps
module ssr_readout
  import ssr_pkg::*;
(
  // system clock and reset
  input  wire logic             clock,
  input  wire logic             sys_rst,
  // host link pins
  input  wire logic             select_shutdown_n,
  input  wire logic             conversion_clock,
  output ssr_pin_t              serial_out,
  // analog front end
  input  wire logic             comparator_high,
  output logic                  track_enable,
  output logic [RES_W-1:0]      dac_code,
  // finished results
  output logic                  result_valid,
  output ssr_result_t           result_data,
  input  wire logic             result_ready
);
  logic              sel_s1;
  logic              sel_s2;
  logic              sel_s3;
  logic              clk_s1;
  logic              clk_s2;
  logic              clk_s3;
  logic              fall;
  logic              sel_fall;
  logic              shutdown;
  logic              run;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  edge_no;
  logic [RES_W-1:0]  res;
  logic [TAG_W-1:0]  tag;
  logic              push_valid;
  ssr_result_t       push_data;
  logic              fifo_ready;

  // pins come from the host's domain: two flops before any use
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
      sel_s3 <= 1'b1;
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
    end else begin
      sel_s1 <= select_shutdown_n;
      sel_s2 <= sel_s1;
      sel_s3 <= sel_s2;
      clk_s1 <= conversion_clock;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
    end
  end

  // edge events, derived only from the settled stages
  assign shutdown = sel_s2;
  assign sel_fall = sel_s3 && !sel_s2;
  assign fall     = clk_s3 && !clk_s2 && !sel_s2;
  assign edge_no  = cnt + CNT_W'(1);

  // falling edge counter, saturates once only zeros remain
  always_ff @(posedge clock) begin
    if (sys_rst || shutdown) begin
      cnt <= CNT_RST;
    end else if (fall && cnt <= LSB_LAST) begin
      cnt <= edge_no;
    end
  end

  // a cycle only runs if the queue can take its result; a full
  // queue skips the conversion rather than lose a finished word
  always_ff @(posedge clock) begin
    if (sys_rst || shutdown) begin
      run <= 1'b0;
    end else if (sel_fall) begin
      run <= fifo_ready;
    end
  end

  // sample window: track from select low up to the fifth fall
  always_ff @(posedge clock) begin
    if (sys_rst || shutdown) begin
      track_enable <= 1'b0;
    end else if (sel_fall) begin
      track_enable <= fifo_ready;
    end else if (fall && edge_no == TRACK_FALLS) begin
      track_enable <= 1'b0;
    end
  end

  // successive approximation: one decision per falling edge
  always_ff @(posedge clock) begin
    if (sys_rst || shutdown) begin
      res      <= CODE_RST;
      dac_code <= CODE_RST;
    end else if (fall && run) begin
      if (edge_no == TRACK_FALLS) begin
        res      <= CODE_RST;
        dac_code <= TRIAL_FIRST;
      end else if (edge_no > TRACK_FALLS && edge_no <= MSB_LAST) begin
        for (int i = 0; i < RES_W; i++) begin
          if (MSB_LAST - edge_no == CNT_W'(i)) begin
            res[i]      <= comparator_high;
            dac_code[i] <= comparator_high;
            if (i > 0) begin
              dac_code[i-1] <= 1'b1;                 // next trial bit
            end
          end
        end
      end
    end
  end

  // serial pin: enabled on the first fall, bits change only on falls
  always_ff @(posedge clock) begin
    if (sys_rst || shutdown) begin
      serial_out <= '0;
    end else if (fall) begin
      serial_out.oe   <= 1'b1;
      serial_out.data <= 1'b0;
      if (run && edge_no > TRACK_FALLS && edge_no <= MSB_LAST) begin
        serial_out.data <= comparator_high;
      end else if (run && edge_no > MSB_LAST && edge_no <= LSB_LAST) begin
        for (int i = 1; i < RES_W; i++) begin
          if (edge_no - MSB_LAST == CNT_W'(i)) begin
            serial_out.data <= res[i];
          end
        end
      end
      // beyond the lsb-first word the default zero stands
    end
  end

  // hand the result to the queue as the last bit resolves
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      push_valid <= 1'b0;
      push_data  <= '0;
      tag        <= TAG_RST;
    end else begin
      push_valid <= 1'b0;
      if (fall && run && edge_no == MSB_LAST) begin
        push_valid     <= 1'b1;
        push_data.code <= {res[RES_W-1:1], comparator_high};
        push_data.tag  <= tag;
        tag            <= tag + TAG_W'(1);
      end
    end
  end

  ssr_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_valid  (push_valid),
    .in_data   (push_data),
    .in_ready  (fifo_ready),
    .out_valid (result_valid),
    .out_data  (result_data),
    .out_ready (result_ready)
  );

  // checks on the sequencing
  AST_SHUTDOWN_QUIET: assert property (
    @(posedge clock) disable iff (sys_rst)
    shutdown |=> !track_enable && cnt == CNT_RST)
    else $error("shutdown did not stop the cycle");
  AST_HIZ_DESELECT: assert property (
    @(posedge clock) disable iff (sys_rst)
    shutdown |=> !serial_out.oe)
    else $error("output driven while deselected");
  AST_PIN_ON_FALL: assert property (
    @(posedge clock) disable iff (sys_rst)
    !shutdown && !$past(fall) && !$past(shutdown) |-> $stable(serial_out))
    else $error("output moved without a falling edge");
  AST_DAC_PACED: assert property (
    @(posedge clock) disable iff (sys_rst)
    !fall && !shutdown |=> $stable(dac_code))
    else $error("conversion stepped without a clock edge");
  // tracking opens only for a cycle that will actually run
  AST_TRACK_START: assert property (
    @(posedge clock) disable iff (sys_rst)
    sel_fall |=> track_enable == $past(fifo_ready))
    else $error("tracking did not open at select low");
  AST_TRACK_END: assert property (
    @(posedge clock) disable iff (sys_rst)
    fall && run && edge_no == TRACK_FALLS |=> !track_enable
      && dac_code == TRIAL_FIRST)
    else $error("hold did not begin at the fifth fall");
  AST_MSB_BIT: assert property (
    @(posedge clock) disable iff (sys_rst)
    fall && run && edge_no == TRACK_FALLS + 6'h01
      |=> serial_out.data == $past(comparator_high)
      && dac_code[15] == $past(comparator_high))
    else $error("msb not presented first");
  AST_NO_LATENCY: assert property (
    @(posedge clock) disable iff (sys_rst)
    fall && run && edge_no > TRACK_FALLS && edge_no <= MSB_LAST
      |=> serial_out.data == $past(comparator_high))
    else $error("bit not emitted at its own step");
  AST_LSB_FIRST: assert property (
    @(posedge clock) disable iff (sys_rst)
    fall && run && edge_no == MSB_LAST + 6'h01
      |=> serial_out.data == res[1])
    else $error("lsb-first word did not start at bit one");
  // covers the very first trailing zero as well as the saturated tail
  AST_ZEROS_AFTER: assert property (
    @(posedge clock) disable iff (sys_rst)
    fall && edge_no > LSB_LAST |=> serial_out.oe && !serial_out.data)
    else $error("nonzero after the transfer finished");
endmodule

// [verification/ssr_host_model.sv]
// host link master model for the serial readout block
`timescale 1ns/1ps
module ssr_host_model #(
  parameter int HALF = 21  // 84 ns half period, under 6.0MHz
) (
  // pacing clock
  input  wire logic clock,
  // link pins
  output logic      select_shutdown_n,
  output logic      conversion_clock,
  input  wire logic sdata,
  input  wire logic soe,
  // bench probe of the track output
  input  wire logic trk
);
  logic [63:0] bits;  // sampled serial bits, index is fall minus one
  logic [63:0] trks;  // track level at each sample
  // link idles deselected, clock stands high outside frames
  initial begin
    select_shutdown_n = 1'b1;
    conversion_clock  = 1'b1;
  end
  // one frame of n falls; a released pin reads as unknown so it never
  // passes for a driven bit
  task automatic frame(input int n);
    @(negedge clock) select_shutdown_n = 1'b0;
    repeat (HALF) @(negedge clock);
    for (int i = 0; i < n; i++) begin
      conversion_clock = 1'b0;
      repeat (HALF) @(negedge clock);
      conversion_clock = 1'b1;
      bits[i] = soe ? sdata : 1'bx;  // sample on rise
      trks[i] = trk;
      repeat (HALF) @(negedge clock);
    end
    select_shutdown_n = 1'b1;
    repeat (4 * HALF) @(negedge clock);
  endtask
endmodule

// [verification/tb_top.sv]
// self-checking bench for the serial sar readout block
`timescale 1ns/1ps
module tb_top
  import ssr_pkg::*;
;
  // clock, reset and design signals
  logic        clock;
  logic        sys_rst;
  logic        select_shutdown_n;
  logic        conversion_clock;
  ssr_pin_t    serial_out;
  logic        comparator_high;
  logic        track_enable;
  logic [15:0] dac_code;
  logic        result_valid;
  ssr_result_t result_data;
  logic        result_ready;
  logic [15:0] analog;  // level the comparator sees
  logic [3:0]  q_tag;   // tag of the next queued result
  int          fails;
  int          total_checks;

  // ideal comparator standing in for the analog core
  assign comparator_high = (analog >= dac_code);

  ssr_readout dut_u (
    .clock, .sys_rst, .select_shutdown_n, .conversion_clock,
    .serial_out, .comparator_high, .track_enable, .dac_code,
    .result_valid, .result_data, .result_ready
  );
  ssr_host_model host_u (
    .clock, .select_shutdown_n, .conversion_clock,
    .sdata(serial_out.data), .soe(serial_out.oe), .trk(track_enable)
  );

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // run one frame and judge every sampled bit and track level
  task automatic frame_chk(input logic [15:0] v, input int n,
                           input bit skip);
    logic eb;
    analog = v;
    host_u.frame(n);
    for (int i = 0; i < n; i++) begin
      if (skip || i < 5 || i > 35) eb = 1'b0;
      else if (i < 21) eb = v[20 - i];
      else eb = v[i - 20];
      chk(20'(host_u.bits[i]), 20'(eb));
      chk(20'(host_u.trks[i]), 20'(!skip && i < 4));
    end
    chk(20'(serial_out.oe), 20'h00000);
  endtask

  // take the queue head; ready spans exactly one rising edge
  task automatic pop(input logic [15:0] v);
    chk(20'(result_valid), 20'h00001);
    chk(result_data, {q_tag, v});
    @(negedge clock) result_ready = 1'b1;
    @(negedge clock) result_ready = 1'b0;
    q_tag++;
  endtask

  // full frame: msb first, lsb first, then zeros
  task automatic t_full();
    frame_chk(16'ha5c3, 40, 1'b0);
    pop(16'ha5c3);
  endtask

  // deselect mid conversion must drop the result
  task automatic t_abort();
    frame_chk(16'h3c5a, 10, 1'b0);
    chk(20'(result_valid), 20'h00000);
  endtask

  // shortest legal frame at both ends of the code range
  task automatic t_min();
    frame_chk(16'hffff, 22, 1'b0);
    pop(16'hffff);
    frame_chk(16'h0000, 22, 1'b0);
    pop(16'h0000);
  endtask

  // user stalls until the queue refuses, then drains it empty
  task automatic t_fill();
    for (int k = 1; k <= 8; k++) begin
      frame_chk(16'(k * 16'h1111), 22, 1'b0);
    end
    frame_chk(16'h7777, 22, 1'b1);  // skipped while full
    for (int k = 1; k <= 8; k++) begin
      pop(16'(k * 16'h1111));
    end
    chk(20'(result_valid), 20'h00000);
  endtask

  task automatic conclude();
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // 4 ns system clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // run needs about 60 us; cut a hang well beyond that
  initial begin
    #200000;
    fails++;
    conclude();
  end

  // reset, then the scenarios
  initial begin
    sys_rst = 1'b1;
    result_ready = 1'b0;
    analog = 16'h0000;
    q_tag = 4'h0;
    fails = 0;
    total_checks = 0;
    repeat (12) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    t_full();
    t_abort();
    t_min();
    t_fill();
    conclude();
  end
endmodule
